/* File: verilog/ssf_pkg.sv */
// Constants shared by the serial status flag block.
package ssf_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_CARD = 8'h0C;
    localparam logic [7:0] OFF_ETU = 8'h10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Status bit positions.
    localparam int B_TX_EMPTY = 7;
    localparam int B_RX_FULL = 6;
    localparam int B_OVERRUN = 5;
    localparam int B_FRAME = 4;
    localparam int B_PARITY = 3;
    localparam int B_TX_DONE = 2;
    localparam int B_MP_RX = 1;
    localparam int B_MP_TX = 0;
    // Clearable flags sit contiguously in bits 7 down to 3.
    localparam int CLR_LO = 3;
    localparam int CLR_N = 5;
    localparam logic [7:0] STATUS_RST = 8'h84;
    // Mode register fields.
    localparam int M_SYNC = 0;
    localparam int M_PAR_EN = 1;
    localparam int M_ODD = 2;
    localparam int M_TWO_STOP = 3;
    localparam int M_MP_FMT = 4;
    localparam int M_GUARD = 5;
    localparam int MODE_W = 6;
    localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
    // Control register fields.
    localparam int C_RX_ON = 0;
    localparam int C_TX_ON = 1;
    // Bit period in core clocks, shared with the shift datapath.
    localparam int ETU_W = 16;
    localparam logic [ETU_W-1:0] ETU_RST = 16'h0010;
    // Guard delays counted in half bit periods.
    localparam int HALF_W = 3;
    localparam logic [HALF_W-1:0] GUARD_HALVES_LONG = 3'h5;
    localparam logic [HALF_W-1:0] GUARD_HALVES_SHORT = 3'h2;
    localparam logic [ETU_W-1:0] HALF_MIN = 16'h0001;
endpackage

/* File: verilog/ssf_guard_if.sv */
// Handshake between the status logic and the guard timer.
`timescale 1ns/10ps
interface ssf_guard_if;
    import ssf_pkg::*;
    logic start;
    logic [HALF_W-1:0] halves;
    logic [ETU_W-1:0] half_cycles;
    logic done;
    modport ctrl (output start, output halves, output half_cycles, input done);
    modport timer (input start, input halves, input half_cycles, output done);
endinterface

/* File: verilog/ssf_guard_timer.sv */
// Guard timer that counts a number of half bit periods.
`timescale 1ns/10ps
module ssf_guard_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    ssf_guard_if.timer g
);
    import ssf_pkg::*;

    typedef enum logic {SSF_IDLE = 1'b0, SSF_RUN = 1'b1} ssf_tstate_t;

    ssf_tstate_t state_q;
    logic [ETU_W-1:0] cyc_q;
    logic [HALF_W-1:0] half_q;
    logic done_q;

    // End of one half period and end of the last one.
    wire half_end = (cyc_q == HALF_MIN);
    wire last_half = half_end && (half_q == HALF_W'(1));

    // A start restarts the count, so a second character reloads it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SSF_IDLE;
            cyc_q <= HALF_MIN;
            half_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                SSF_IDLE: begin
                    if (g.start) begin
                        state_q <= SSF_RUN;
                        cyc_q <= g.half_cycles;
                        half_q <= g.halves;
                    end
                end
                SSF_RUN: begin
                    if (g.start) begin
                        cyc_q <= g.half_cycles;
                        half_q <= g.halves;
                    end else if (last_half) begin
                        state_q <= SSF_IDLE;
                        done_q <= 1'b1;
                    end else if (half_end) begin
                        cyc_q <= g.half_cycles;
                        half_q <= half_q - HALF_W'(1);
                    end else begin
                        cyc_q <= cyc_q - HALF_MIN;
                    end
                end
            endcase
        end
    end

    assign g.done = done_q;

    a_guard_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        g.start && g.half_cycles > HALF_MIN |=> !done_q [*2])
        else $error("guard timer ended too early");
endmodule

/* File: verilog/ssf_status.sv */
// Status flags, multiprocessor bits and APB registers of one serial channel.
`timescale 1ns/10ps
module ssf_status (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ssf_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ssf_pkg::DATA_W-1:0] pwdata,
    output logic [ssf_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby,
    input wire logic rx_done,
    input wire logic [7:0] rx_data,
    input wire logic rx_par_bit,
    input wire logic rx_stop_bit,
    input wire logic rx_mp_bit,
    input wire logic err_sample,
    input wire logic err_line,
    input wire logic tx_load,
    input wire logic tx_last_bit,
    input wire logic dma_tx_write,
    input wire logic dma_rx_read,
    output logic [7:0] rx_buffer,
    output logic rx_allow,
    output logic tx_allow,
    output logic mp_tx_out,
    output logic [ssf_pkg::ETU_W-1:0] bit_cycles
);
    import ssf_pkg::*;

    // Address match, used by every register decode.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic rst_meta_q, rst_n;
    logic err_meta_q, err_sync_q;
    logic pready_q, pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic [7:0] stat_q, stat_d;
    logic [CLR_N-1:0] armed_q, armed_d;
    logic [MODE_W-1:0] mode_q;
    logic rx_on_q, tx_on_q, tx_on_prev_q, smart_q;
    logic [ETU_W-1:0] etu_q;
    logic [7:0] rx_buf_q;
    logic rx_allow_q, tx_allow_q, mp_tx_q;

    // Reset release through two flip-flops.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // The returned error line is a pin and is synchronised before use.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_meta_q <= 1'b1;
            err_sync_q <= 1'b1;
        end else begin
            err_meta_q <= err_line;
            err_sync_q <= err_meta_q;
        end
    end

    // APB decode; one wait state, the transfer completes with pready.
    wire acc = psel && penable && !pready_q;
    wire done = psel && penable && pready_q;
    wire wr = done && pwrite;
    wire rd = done && !pwrite;
    wire a_stat = hit(paddr, OFF_STATUS);
    wire a_mode = hit(paddr, OFF_MODE);
    wire a_ctrl = hit(paddr, OFF_CTRL);
    wire a_card = hit(paddr, OFF_CARD);
    wire a_etu = hit(paddr, OFF_ETU);
    wire mapped = a_stat || a_mode || a_ctrl || a_card || a_etu;
    wire wr_stat = wr && a_stat;
    wire rd_stat = rd && a_stat;

    // Mode fields.
    wire sync_m = mode_q[M_SYNC];
    wire par_en = mode_q[M_PAR_EN];
    wire odd_m = mode_q[M_ODD];
    wire mp_fmt = mode_q[M_MP_FMT];
    wire guard_sel = mode_q[M_GUARD];
    wire std = standby;

    // Flag views.
    wire tx_empty_flag = stat_q[B_TX_EMPTY];
    wire rx_full_flag = stat_q[B_RX_FULL];
    wire orer = stat_q[B_OVERRUN];
    wire framing_error_flag = stat_q[B_FRAME];
    wire parity_fault_flag = stat_q[B_PARITY];
    wire tx_done_flag = stat_q[B_TX_DONE];

    wire [CLR_N-1:0] clr = armed_q & ~pwdata[B_TX_EMPTY:CLR_LO] & {CLR_N{wr_stat}};
    wire clr_tx_empty_flag = clr[B_TX_EMPTY-CLR_LO];
    wire clr_rx_full_flag = clr[B_RX_FULL-CLR_LO];
    wire clr_orer = clr[B_OVERRUN-CLR_LO];
    wire clr_fer = clr[B_FRAME-CLR_LO];
    wire clr_per = clr[B_PARITY-CLR_LO];

    wire rx_block = orer || parity_fault_flag || (framing_error_flag && !smart_q);
    wire tx_block = sync_m && rx_block;

    wire stop_bad = !sync_m && !smart_q && !rx_stop_bit;
    // parity over data and parity bit
    wire par_bad = par_en && !sync_m && ((^{rx_data, rx_par_bit}) != odd_m);

    // Receive outcome of one character.
    wire rx_go = rx_done && rx_on_q && !rx_block;
    wire rx_ovr = rx_go && rx_full_flag;
    wire rx_load = rx_go && !rx_ovr;
    wire rx_ok = rx_load && !stop_bad && !par_bad;
    wire fer_set = rx_load && stop_bad;
    wire per_set = rx_load && par_bad;
    wire ers_set = smart_q && err_sample && !err_sync_q;
    wire mp_cap = rx_load && mp_fmt && !sync_m;

    // Transmit events.
    wire tx_off = tx_on_prev_q && !tx_on_q;
    wire tx_empty_flag_clr = clr_tx_empty_flag || dma_tx_write;
    logic guard_done;
    wire tx_done_flag_norm = !smart_q && tx_last_bit && tx_empty_flag;
    // guard start after a clean character
    wire guard_go = smart_q && tx_last_bit && tx_empty_flag && !framing_error_flag;
    // transmit off in either mode; in smart card mode only while the error flag is clear
    wire tx_done_flag_off = tx_off && (!smart_q || !framing_error_flag);
    wire tx_done_flag_set = tx_done_flag_norm || tx_done_flag_off || (guard_done && smart_q && !framing_error_flag);

    // Next status value; a set wins over a clear, and standby forces the reset value over both.
    always_comb begin
        stat_d = stat_q;
        stat_d[B_TX_EMPTY] = std || tx_off || tx_load || (tx_empty_flag && !tx_empty_flag_clr);
        stat_d[B_RX_FULL] = !std && (rx_ok || (rx_full_flag && !(clr_rx_full_flag || dma_rx_read)));
        stat_d[B_OVERRUN] = !std && (rx_ovr || (orer && !clr_orer));
        stat_d[B_FRAME] = !std && (fer_set || ers_set || (framing_error_flag && !clr_fer));
        // parity flag kept by receive off
        stat_d[B_PARITY] = !std && (per_set || (parity_fault_flag && !clr_per));
        stat_d[B_TX_DONE] = std || tx_done_flag_set || (tx_done_flag && !tx_empty_flag_clr);
        stat_d[B_MP_RX] = !std && (mp_cap ? rx_mp_bit : stat_q[B_MP_RX]);
        stat_d[B_MP_TX] = !std && (wr_stat ? pwdata[B_MP_TX] : stat_q[B_MP_TX]);
    end

    assign armed_d = (armed_q | {CLR_N{rd_stat}}) & stat_q[B_TX_EMPTY:CLR_LO] & ~clr;

    // Status, armed bits and receive buffer.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= STATUS_RST;
            armed_q <= '0;
            rx_buf_q <= 8'h00;
        end else begin
            stat_q <= stat_d;
            armed_q <= std ? '0 : armed_d;
            if (rx_load) begin
                rx_buf_q <= rx_data;
            end
        end
    end

    // Software registers; standby returns them to their reset values.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_RST;
            rx_on_q <= 1'b0;
            tx_on_q <= 1'b0;
            smart_q <= 1'b0;
            etu_q <= ETU_RST;
        end else if (std) begin
            mode_q <= MODE_RST;
            rx_on_q <= 1'b0;
            tx_on_q <= 1'b0;
            smart_q <= 1'b0;
            etu_q <= ETU_RST;
        end else if (wr) begin
            if (a_mode) begin
                mode_q <= pwdata[MODE_W-1:0];
            end
            if (a_ctrl) begin
                rx_on_q <= pwdata[C_RX_ON];
                tx_on_q <= pwdata[C_TX_ON];
            end
            if (a_card) begin
                smart_q <= pwdata[0];
            end
            if (a_etu) begin
                etu_q <= pwdata[ETU_W-1:0];
            end
        end
    end

    // Read data selection.
    wire [DATA_W-1:0] rdata =
        a_stat ? DATA_W'(stat_q) :
        a_mode ? DATA_W'(mode_q) :
        a_ctrl ? DATA_W'({tx_on_q, rx_on_q}) :
        a_card ? DATA_W'(smart_q) :
        a_etu ? DATA_W'(etu_q) : 32'h0000_0000;

    // APB answer registers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc && !mapped;
            if (acc && !pwrite) begin
                prdata_q <= rdata;
            end
        end
    end

    // Registered user outputs and the transmit-off edge detector.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_on_prev_q <= 1'b0;
            rx_allow_q <= 1'b0;
            tx_allow_q <= 1'b0;
            mp_tx_q <= 1'b0;
        end else begin
            tx_on_prev_q <= tx_on_q;
            rx_allow_q <= rx_on_q && !rx_block;
            tx_allow_q <= tx_on_q && !tx_block;
            mp_tx_q <= stat_q[B_MP_TX] && mp_fmt && !sync_m && tx_on_q && !tx_block;
        end
    end

    // Guard timer for the smart card transmit end.
    ssf_guard_if gif ();
    assign gif.start = guard_go;
    assign gif.halves = guard_sel ? GUARD_HALVES_SHORT : GUARD_HALVES_LONG;
    // half of the programmed bit period
    assign gif.half_cycles = (etu_q < 16'h0002) ? HALF_MIN : (etu_q >> 1);
    assign guard_done = gif.done;

    ssf_guard_timer u_guard (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .g(gif.timer)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_buffer = rx_buf_q;
    assign rx_allow = rx_allow_q;
    assign tx_allow = tx_allow_q;
    assign mp_tx_out = mp_tx_q;
    assign bit_cycles = etu_q;

    a_stop_check: assert property (@(posedge core_clk) disable iff (!rst_n)
        fer_set && !std |=> framing_error_flag)
        else $error("framing flag missed a zero stop bit");

    a_card_noframe: assert property (@(posedge core_clk) disable iff (!rst_n)
        smart_q && rx_done && !rx_stop_bit && !framing_error_flag && !ers_set |=> !framing_error_flag)
        else $error("framing error seen in smart card mode");

    a_card_err: assert property (@(posedge core_clk) disable iff (!rst_n)
        ers_set && !std |=> framing_error_flag ##1 (framing_error_flag || $past(clr_fer) || $past(std)))
        else $error("card error flag not set");

    a_txoff_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        framing_error_flag && tx_off && !clr_fer && !std |=> framing_error_flag)
        else $error("transmit off changed card error flag");

    a_parity_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_done && rx_on_q && !rx_block && !rx_full_flag && par_bad && !std |=> parity_fault_flag && !rx_full_flag)
        else $error("parity error not flagged");

    a_err_buffer: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_load && stop_bad && !std |=> rx_buf_q == $past(rx_data) && !rx_full_flag)
        else $error("framing error character handling wrong");

    a_rx_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
        (parity_fault_flag || orer) |=> $stable(rx_buf_q))
        else $error("reception continued during an error");

    a_done_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_stat && pwdata[B_TX_DONE] && !tx_done_flag && !tx_done_flag_set && !std |=> !tx_done_flag)
        else $error("transmit done was written");

    a_done_dma: assert property (@(posedge core_clk) disable iff (!rst_n)
        dma_tx_write && tx_done_flag && !tx_done_flag_set && !std |=> !tx_done_flag)
        else $error("transmit done not cleared by dma write");

    a_mp_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !mp_cap && !std |=> $stable(stat_q[B_MP_RX]))
        else $error("received multiprocessor bit changed");

    a_mp_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync_m |=> !mp_tx_q)
        else $error("multiprocessor bit sent in synchronous mode");
endmodule

/* File: dv/ssf_peer.sv */
// Far-side serial peer that delivers received characters and the error line.
`timescale 1ns/10ps
module ssf_peer (
    input wire logic core_clk,
    output logic rx_done,
    output logic [7:0] rx_data,
    output logic rx_par_bit,
    output logic rx_stop_bit,
    output logic rx_mp_bit,
    output logic err_line
);
    // Lines start idle; the error line rests high through its pull-up.
    initial begin
        rx_done = 1'b0;
        rx_data = 8'h00;
        rx_par_bit = 1'b0;
        rx_stop_bit = 1'b1;
        rx_mp_bit = 1'b0;
        err_line = 1'b1;
    end

    // Delivers one whole character, then scrambles the released lines.
    task automatic send(input logic [7:0] d, input logic p, input logic s, input logic m);
        @(posedge core_clk);
        rx_data <= d;
        rx_par_bit <= p;
        rx_stop_bit <= s;
        rx_mp_bit <= m;
        rx_done <= 1'b1;
        @(posedge core_clk);
        rx_done <= 1'b0;
        rx_data <= ~d;
        rx_par_bit <= ~p;
        rx_stop_bit <= ~s;
        rx_mp_bit <= ~m;
    endtask

    // Pulls the returned error line low or lets it go high again.
    task automatic drive_err(input logic v);
        @(posedge core_clk);
        err_line <= v;
    endtask
endmodule

/* File: dv/ssf_status_tb.sv */
// Self-checking testbench for the serial status flag block.
`timescale 1ns/10ps
module ssf_status_tb;
    import ssf_pkg::*;
    localparam logic [5:0] EV_SB = 6'h20;
    localparam logic [5:0] EV_ES = 6'h10;
    localparam logic [5:0] EV_LD = 6'h08;
    localparam logic [5:0] EV_LB = 6'h04;
    localparam logic [5:0] EV_DW = 6'h02;
    localparam logic [5:0] EV_DR = 6'h01;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] ev = 6'h00;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_par_bit;
    logic rx_stop_bit;
    logic rx_mp_bit;
    logic err_line;
    logic [7:0] rx_buffer;
    logic rx_allow;
    logic mp_tx_out;
    logic tx_allow;
    logic [15:0] bit_cycles;
    logic [31:0] rd;
    logic se;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;

    ssf_peer peer (.core_clk(core_clk), .rx_done(rx_done), .rx_data(rx_data),
        .rx_par_bit(rx_par_bit), .rx_stop_bit(rx_stop_bit), .rx_mp_bit(rx_mp_bit),
        .err_line(err_line));

    ssf_status dut (.core_clk(core_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby(ev[5]), .rx_done(rx_done),
        .rx_data(rx_data), .rx_par_bit(rx_par_bit), .rx_stop_bit(rx_stop_bit),
        .rx_mp_bit(rx_mp_bit), .err_sample(ev[4]), .err_line(err_line),
        .tx_load(ev[3]), .tx_last_bit(ev[2]), .dma_tx_write(ev[1]),
        .dma_rx_read(ev[0]), .rx_buffer(rx_buffer), .rx_allow(rx_allow),
        .tx_allow(tx_allow), .mp_tx_out(mp_tx_out), .bit_cycles(bit_cycles));

    // Free-running core clock.
    always #2.5 core_clk = ~core_clk;

    task automatic stop_test();
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hung run short and reports it as a mismatch.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors = errors + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rs(input logic [7:0] e);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(rd, {24'h00_0000, e});
    endtask

    // Raises the selected one-cycle event strobes.
    task automatic pulse(input logic [5:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= 6'h00;
    endtask

    // Main sequence of register and datapath scenarios.
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rs(8'h84);
        // An odd bit period differs from the reset value but halves to the same guard step.
        wr(OFF_ETU, 32'h0000_0011);
        @(posedge core_clk);
        chk(32'(bit_cycles), 32'h0000_0011);
        wr(OFF_MODE, 32'h0000_0012);
        wr(OFF_CTRL, 32'h0000_0003);
        peer.send(8'h35, 1'b0, 1'b1, 1'b1);
        rs(8'hC6);
        chk(32'(rx_buffer), 32'h0000_0035);
        pulse(EV_DR);
        peer.send(8'h3C, 1'b1, 1'b1, 1'b1);
        wr(OFF_STATUS, 32'h0000_00F6);
        rs(8'h8E);
        chk(32'(rx_buffer), 32'h0000_003C);
        chk(32'(rx_allow), 32'h0000_0000);
        chk(32'(tx_allow), 32'h0000_0001);
        peer.send(8'hAA, 1'b0, 1'b1, 1'b0);
        @(posedge core_clk);
        chk(32'(rx_buffer), 32'h0000_003C);
        wr(OFF_CTRL, 32'h0000_0002);
        rs(8'h8E);
        wr(OFF_STATUS, 32'h0000_00F6);
        rs(8'h86);
        wr(OFF_MODE, 32'h0000_001E);
        wr(OFF_CTRL, 32'h0000_0003);
        peer.send(8'h01, 1'b1, 1'b1, 1'b0);
        rs(8'h8C);
        wr(OFF_STATUS, 32'h0000_00F6);
        peer.send(8'h01, 1'b0, 1'b0, 1'b0);
        rs(8'h94);
        chk(32'(rx_buffer), 32'h0000_0001);
        chk(32'(rx_allow), 32'h0000_0000);
        wr(OFF_STATUS, 32'h0000_00EF);
        rs(8'h85);
        wr(OFF_STATUS, 32'h0000_00FF);
        chk(32'(mp_tx_out), 32'h0000_0001);
        pulse(EV_DW);
        rs(8'h01);
        pulse(EV_LD);
        pulse(EV_LB);
        rs(8'h85);
        wr(OFF_STATUS, 32'h0000_00FB);
        rs(8'h85);
        wr(OFF_STATUS, 32'h0000_007F);
        rs(8'h01);
        wr(OFF_CTRL, 32'h0000_0001);
        rs(8'h85);
        wr(OFF_CARD, 32'h0000_0001);
        wr(OFF_MODE, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0003);
        peer.send(8'h5A, 1'b0, 1'b0, 1'b0);
        rs(8'hC5);
        pulse(EV_DR);
        peer.drive_err(1'b0);
        repeat (4) @(posedge core_clk);
        pulse(EV_ES);
        peer.drive_err(1'b1);
        rs(8'h95);
        wr(OFF_CTRL, 32'h0000_0001);
        rs(8'h95);
        wr(OFF_STATUS, 32'h0000_00EF);
        rs(8'h85);
        wr(OFF_CTRL, 32'h0000_0003);
        pulse(EV_DW);
        rs(8'h01);
        wr(OFF_CTRL, 32'h0000_0001);
        rs(8'h85);
        wr(OFF_CTRL, 32'h0000_0003);
        for (int g = 0; g < 2; g++) begin
            wr(OFF_MODE, (g == 0) ? 32'h0000_0000 : 32'h0000_0020);
            pulse(EV_DW);
            pulse(EV_LD);
            pulse(EV_LB);
            rs(8'h81);
            repeat (20) @(posedge core_clk);
            rs((g == 0) ? 8'h81 : 8'h85);
            repeat (20) @(posedge core_clk);
            rs(8'h85);
        end
        peer.drive_err(1'b0);
        repeat (4) @(posedge core_clk);
        pulse(EV_ES);
        peer.drive_err(1'b1);
        pulse(EV_SB);
        rs(8'h84);
        // A parity error kept into synchronous mode stalls sending and the bit to send.
        wr(OFF_MODE, 32'h0000_0002);
        wr(OFF_CTRL, 32'h0000_0003);
        peer.send(8'h01, 1'b0, 1'b1, 1'b0);
        wr(OFF_MODE, 32'h0000_0011);
        wr(OFF_STATUS, 32'h0000_00F9);
        rs(8'h8D);
        chk(32'(tx_allow), 32'h0000_0000);
        chk(32'(mp_tx_out), 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk(32'(se), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        stop_test();
    end
endmodule
